// ==== fpx_pkg.sv ====
// package for the fp status, fp move and integer load/store execution block
package fpx_pkg;

  // decoded operation classes
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_LOAD     = 4'h1,
    OP_STORE    = 4'h2,
    OP_FMOVE    = 4'h3,
    OP_FS_READ  = 4'h4,
    OP_FS_TO_CR = 4'h5,
    OP_FS_CLR   = 4'h6,
    OP_FS_SET   = 4'h7,
    OP_FS_IMM   = 4'h8,
    OP_FS_MASK  = 4'h9,
    OP_SYNC     = 4'hA
  } fpx_op_t;

  // effective address forms
  typedef enum logic [1:0] {
    AM_DISP  = 2'h0,
    AM_INDEX = 2'h1,
    AM_BASE  = 2'h2
  } fpx_amode_t;

  // register-to-register floating move kinds
  typedef enum logic [1:0] {
    MV_COPY = 2'h0,
    MV_ABS  = 2'h1,
    MV_NEG  = 2'h2,
    MV_NABS = 2'h3
  } fpx_mv_t;

  // access sizes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } fpx_size_t;

  // pre-decoded instruction
  typedef struct packed {
    fpx_op_t    op;
    fpx_amode_t amode;
    logic       update;
    logic       algebraic;
    fpx_size_t  size;
    fpx_mv_t    mv;
    logic       record_bit;  // instruction bit 31
    logic [4:0] dest_reg;
    logic [4:0] base_reg;
    logic [4:0] index_reg;
    logic [4:0] src_reg;
    logic [15:0] disp;
    logic [7:0] field_select_mask;
    logic [2:0] field_d;
    logic [2:0] field_s;
    logic [3:0] immediate_value;
    logic [4:0] bit_num;
  } fpx_instr_t;

  // word-wide request to the data cache
  typedef struct packed {
    logic [29:0] word_addr;
    logic [3:0]  byte_en;   // bit 3 is the lowest byte address
    logic        write;
    logic [31:0] wdata;
  } fpx_mem_req_t;

  // attributes driven on instruction fetch transactions
  typedef struct packed {
    logic coherent;
    logic via_dcache;
  } fpx_fetch_attr_t;

  // one-hot control states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_REQ   = 4'h2,
    ST_RSP   = 4'h4,
    ST_FSYNC = 4'h8
  } fpx_state_t;

  localparam logic [4:0]  FS_NI_IDX    = 5'h02;   // non-ieee mode bit position
  localparam logic [2:0]  CR1_FIELD    = 3'h1;
  localparam logic [31:0] FS_RESET     = 32'h0000_0000;
  localparam logic [31:0] CR_RESET     = 32'h0000_0000;
  localparam logic [4:0]  REG_ZERO     = 5'h00;
  localparam logic [10:0] FP_EXP_ZERO  = 11'h000;

endpackage

// ==== fpx_exec.sv ====
// fp status, fp move and integer load/store execution unit
// Functional notes
// RQ1 - fp status ops wait for fp quiet
// RQ2 - six fp status operations supported
// RQ3 - masked field update costs one cycle always
// RQ4 - fp moves copy, leave status untouched
// RQ5 - record bit updates condition field one
// RQ6 - copy, abs, negate, negative abs moves
// RQ7 - loads/stores issued in order, sync orders
// RQ8 - fetch never reads the data cache
// RQ9 - fetch never drives coherence attribute
// RQ10 - address: base+disp, base+index, base
// RQ11 - misaligned accesses done in two beats
// RQ12 - load writes dest, update writes base
// RQ13 - zero/algebraic loads in all forms
// RQ14 - all loads share one latency
// RQ15 - store writes low bytes of source
// RQ16 - store update writes address to base
// RQ17 - store original source before base update
// RQ18 - store with record bit is invalid
// RQ19 - store update with base zero invalid
// RQ20 - stores in all three address forms
// RQ21 - field one gets fp status summaries
// RQ22 - non-ieee mode flushes denormals to zero
`timescale 1ns/1ps
`default_nettype none
module fpx_exec
  import fpx_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            instr_valid_i,
  input  wire fpx_instr_t      instr_i,
  output logic                 instr_ready_o,
  input  wire logic            fp_busy_i,
  output logic                 fp_hold_o,
  output logic                 mem_req_valid_o,
  output fpx_mem_req_t         mem_req_o,
  input  wire logic            mem_req_ready_i,
  input  wire logic            mem_rsp_valid_i,
  input  wire logic [31:0]     mem_rsp_data_i,
  output fpx_fetch_attr_t      fetch_attr_o,
  output logic                 done_o,
  output logic                 invalid_form_o,
  input  wire logic [4:0]      dbg_gpr_sel_i,
  output logic [31:0]          dbg_gpr_o,
  input  wire logic [4:0]      dbg_fpr_sel_i,
  output logic [63:0]          dbg_fpr_o,
  output logic [31:0]          fp_status_o,
  output logic [31:0]          cond_reg_o
);

  fpx_state_t  state_r, state_nxt;
  fpx_instr_t  ins_r;
  logic [31:0] gpr_r [32];
  logic [63:0] fpr_r [32];
  logic [31:0] fp_status_r, fp_status_nxt;
  logic [31:0] cr_r;
  logic [31:0] ea_r;
  logic [31:0] st_data_r;
  logic [31:0] ld_hi_r;
  logic        beat_r;
  logic        done_r;
  logic        invalid_r;
  logic [31:0] dbg_gpr_r;
  logic [63:0] dbg_fpr_r;

  // accept decode
  wire logic accept      = instr_valid_i && instr_ready_o;
  wire logic is_mem      = (instr_i.op == OP_LOAD) || (instr_i.op == OP_STORE);
  wire logic is_fs       = (instr_i.op >= OP_FS_READ) && (instr_i.op <= OP_FS_MASK);
  wire logic st_rec_bad  = (instr_i.op == OP_STORE) && instr_i.record_bit;            // RQ18
  wire logic st_zero_bad = (instr_i.op == OP_STORE) && instr_i.update
                           && (instr_i.base_reg == REG_ZERO);                         // RQ19
  wire logic bad_form    = st_rec_bad || st_zero_bad;

  // effective address: base+disp, base+index or base alone
  wire logic [31:0] base_val = (instr_i.base_reg == REG_ZERO && !instr_i.update)
                               ? 32'h0000_0000 : gpr_r[instr_i.base_reg];
  wire logic [31:0] disp_ext = {{16{instr_i.disp[15]}}, instr_i.disp};
  wire logic [31:0] offs_val = (instr_i.amode == AM_DISP)  ? disp_ext :
                               (instr_i.amode == AM_INDEX) ? gpr_r[instr_i.index_reg] :
                               32'h0000_0000;                                          // RQ10
  wire logic [31:0] ea_calc  = base_val + offs_val;                                    // RQ10

  // byte lane placement, big-endian: lane 3 of byte_en is the lowest address
  wire logic [1:0]  off      = ea_r[1:0];
  wire logic [3:0]  size_m   = (ins_r.size == SZ_BYTE) ? 4'h8 :
                               (ins_r.size == SZ_HALF) ? 4'hC : 4'hF;
  wire logic [7:0]  lane_m   = {size_m, 4'h0} >> off;
  wire logic [31:0] st_left  = (ins_r.size == SZ_BYTE) ? {st_data_r[7:0], 24'h00_0000} :
                               (ins_r.size == SZ_HALF) ? {st_data_r[15:0], 16'h0000} :
                               st_data_r;                                              // RQ15
  wire logic [63:0] st_win   = {st_left, 32'h0000_0000} >> {off, 3'h0};
  wire logic        two_beat = |lane_m[3:0];                                           // RQ11
  wire logic        last     = beat_r || !two_beat;

  // load merge and extension, same path for every load kind
  wire logic [31:0] ld_hi    = beat_r ? ld_hi_r : mem_rsp_data_i;
  wire logic [31:0] ld_lo    = beat_r ? mem_rsp_data_i : 32'h0000_0000;
  wire logic [63:0] ld_join  = {ld_hi, ld_lo} << {off, 3'h0};                          // RQ11
  wire logic [31:0] ld_left  = ld_join[63:32];
  wire logic [31:0] ld_val   =
    (ins_r.size == SZ_BYTE) ? {24'h00_0000, ld_left[31:24]} :
    (ins_r.size == SZ_HALF) ? {{16{ins_r.algebraic & ld_left[31]}}, ld_left[31:16]} :
    ld_left;                                                                           // RQ13

  // memory request
  wire logic rsp_done = (state_r == ST_RSP) && mem_rsp_valid_i;
  assign mem_req_valid_o     = (state_r == ST_REQ);                                   // RQ7
  assign mem_req_o.word_addr = ea_r[31:2] + {29'h0000_0000, beat_r};
  assign mem_req_o.byte_en   = beat_r ? lane_m[3:0] : lane_m[7:4];
  assign mem_req_o.write     = (ins_r.op == OP_STORE);  // RQ20
  assign mem_req_o.wdata     = beat_r ? st_win[31:0] : st_win[63:32];

  // fetch uses its own path and carries no coherence mark
  assign fetch_attr_o.coherent   = 1'b0;                                               // RQ9
  assign fetch_attr_o.via_dcache = 1'b0;                                               // RQ8

  // floating move with optional denormal flush
  wire logic [63:0] fb       = fpr_r[instr_i.src_reg];
  wire logic        mv_sign  = (instr_i.mv == MV_COPY) ? fb[63] :
                               (instr_i.mv == MV_ABS)  ? 1'b0 :
                               (instr_i.mv == MV_NEG)  ? ~fb[63] : 1'b1;               // RQ6
  wire logic        denorm   = (fb[62:52] == FP_EXP_ZERO) && (|fb[51:0]);
  wire logic [63:0] mv_val   = (fp_status_r[FS_NI_IDX] && denorm)
                               ? {mv_sign, 63'h0} : {mv_sign, fb[62:0]};               // RQ22

  // fp status updates, all one cycle whatever the mask
  wire logic [31:0] fs_bit   = 32'h8000_0000 >> ins_r.bit_num;
  wire logic [31:0] fld_d    = 32'hF000_0000 >> {ins_r.field_d, 2'h0};
  wire logic [31:0] fld_s_v  = (fp_status_r << {ins_r.field_s, 2'h0});
  wire logic [31:0] imm_rep  = {8{ins_r.immediate_value}};
  wire logic [31:0] fm_mask;
  wire logic [31:0] frb_lo   = fpr_r[ins_r.src_reg][31:0];
  wire logic        fs_go    = (state_r == ST_FSYNC) && !fp_busy_i;                   // RQ1

  // field select mask expands to nibble mask, mask bit 7 picks field 0
  for (genvar k = 0; k < 8; k++) begin : g_fm
    assign fm_mask[31-4*k -: 4] = {4{ins_r.field_select_mask[7-k]}};
  end

  always_comb begin
    fp_status_nxt = fp_status_r;
    unique case (ins_r.op)
      OP_FS_CLR:  fp_status_nxt = fp_status_r & ~fs_bit;                               // RQ2
      OP_FS_SET:  fp_status_nxt = fp_status_r | fs_bit;                                // RQ2
      OP_FS_IMM:  fp_status_nxt = (fp_status_r & ~fld_d) | (imm_rep & fld_d);          // RQ2
      OP_FS_MASK: fp_status_nxt = (fp_status_r & ~fm_mask) | (frb_lo & fm_mask);       // RQ3
      default:    fp_status_nxt = fp_status_r;
    endcase
  end

  // control sequencing; one access outstanding keeps accesses ordered
  assign instr_ready_o = (state_r == ST_IDLE);
  assign fp_hold_o     = (state_r == ST_FSYNC);                                        // RQ1
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (accept && !bad_form && is_mem) begin
                  state_nxt = ST_REQ;
                end else if (accept && is_fs) begin
                  state_nxt = ST_FSYNC;
                end
      ST_REQ:   if (mem_req_ready_i) begin
                  state_nxt = ST_RSP;
                end
      ST_RSP:   if (mem_rsp_valid_i) begin
                  state_nxt = last ? ST_IDLE : ST_REQ;  // RQ14
                end
      ST_FSYNC: if (!fp_busy_i) begin
                  state_nxt = ST_IDLE;
                end
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // state register and beat tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      beat_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        beat_r <= 1'b0;
      end else if (rsp_done) begin
        beat_r <= !last;
      end
    end
  end

  // operand capture: store data is the source as it was before any update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ins_r     <= '0;
      ea_r      <= 32'h0000_0000;
      st_data_r <= 32'h0000_0000;
      ld_hi_r   <= 32'h0000_0000;
    end else begin
      if (accept) begin
        ins_r     <= instr_i;
        ea_r      <= ea_calc;
        st_data_r <= gpr_r[instr_i.src_reg];                                          // RQ17
      end
      if (rsp_done && !beat_r) begin
        ld_hi_r <= mem_rsp_data_i;
      end
    end
  end

  // general registers: load result and base update at the final beat
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        gpr_r[i] <= 32'h0000_0000;
      end
    end else if (rsp_done && last) begin
      if (ins_r.update) begin
        gpr_r[ins_r.base_reg] <= ea_r;                                                 // RQ16
      end
      if (ins_r.op == OP_LOAD) begin
        gpr_r[ins_r.dest_reg] <= ld_val;                                               // RQ12
      end
    end
  end

  // floating registers: moves and whole status read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        fpr_r[i] <= 64'h0;
      end
    end else if (accept && instr_i.op == OP_FMOVE) begin
      fpr_r[instr_i.dest_reg] <= mv_val;                                               // RQ4
    end else if (fs_go && ins_r.op == OP_FS_READ) begin
      fpr_r[ins_r.dest_reg] <= {32'h0000_0000, fp_status_r};                           // RQ2
    end
  end

  // fp status and condition register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fp_status_r <= FS_RESET;
      cr_r        <= CR_RESET;
    end else if (accept && instr_i.op == OP_FMOVE) begin
      if (instr_i.record_bit) begin
        cr_r[27:24] <= fp_status_r[31:28];                                             // RQ21
      end
    end else if (fs_go) begin
      fp_status_r <= fp_status_nxt;
      if (ins_r.op == OP_FS_TO_CR) begin
        cr_r <= (cr_r & ~fld_d) | ((fld_s_v & 32'hF000_0000) >> {ins_r.field_d, 2'h0}); // RQ2
      end else if (ins_r.record_bit) begin
        cr_r[27:24] <= fp_status_nxt[31:28];                                           // RQ5
      end
    end
  end

  // completion, invalid-form report and debug views
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_r    <= 1'b0;
      invalid_r <= 1'b0;
      dbg_gpr_r <= 32'h0000_0000;
      dbg_fpr_r <= 64'h0;
    end else begin
      done_r    <= (rsp_done && last) || fs_go
                   || (accept && (instr_i.op == OP_FMOVE || instr_i.op == OP_SYNC
                                  || instr_i.op == OP_NONE));                          // RQ7
      invalid_r <= accept && bad_form;
      dbg_gpr_r <= gpr_r[dbg_gpr_sel_i];
      dbg_fpr_r <= fpr_r[dbg_fpr_sel_i];
    end
  end

  assign done_o         = done_r;
  assign invalid_form_o = invalid_r;
  assign dbg_gpr_o      = dbg_gpr_r;
  assign dbg_fpr_o      = dbg_fpr_r;
  assign fp_status_o    = fp_status_r;
  assign cond_reg_o     = cr_r;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence fs_accepted_s;
    accept && is_fs;
  endsequence
  sequence move_plain_s;
    accept && instr_i.op == OP_FMOVE && !instr_i.record_bit;
  endsequence

  fs_waits_busy_a: assert property (fp_hold_o && fp_busy_i // RQ1
                                    |=> fp_hold_o && $stable(fp_status_r))
    else $error("status op ran while fp busy");
  mask_one_cycle_a: assert property (fs_accepted_s ##1 !fp_busy_i |=> done_o) // RQ3
    else $error("status update not done in one cycle");
  move_keeps_fs_a: assert property (accept && instr_i.op == OP_FMOVE // RQ4
                                    |=> $stable(fp_status_r))
    else $error("fp move changed status");
  cr1_unchanged_a: assert property (move_plain_s |=> $stable(cr_r)) // RQ5
    else $error("field one changed without record bit");
  cr1_summary_a: assert property (accept && instr_i.op == OP_FMOVE && instr_i.record_bit // RQ21
                                  |=> cr_r[27:24] == fp_status_r[31:28])
    else $error("field one lacks status summary");
  fetch_attr_a: assert property (!fetch_attr_o.coherent && !fetch_attr_o.via_dcache) // RQ9
    else $error("fetch attribute driven");
  store_rec_bad_a: assert property (accept && st_rec_bad // RQ18
                                    |=> invalid_form_o && !mem_req_valid_o)
    else $error("store with record bit executed");
  store_zero_bad_a: assert property (accept && st_zero_bad // RQ19
                                     |=> invalid_form_o && instr_ready_o)
    else $error("store update on base zero executed");
  req_hold_a: assert property (mem_req_valid_o && !mem_req_ready_i // RQ7
                               |=> mem_req_valid_o && $stable(mem_req_o))
    else $error("memory request dropped or changed");
  store_old_src_a: assert property (accept && instr_i.op == OP_STORE && !bad_form // RQ17
                                    && instr_i.size == SZ_WORD && ea_calc[1:0] == 2'h0
                                    |=> mem_req_o.wdata == $past(gpr_r[instr_i.src_reg]))
    else $error("store data not the original source");

  // loads and stores: beats, latency, fill and base update
  sequence load_last_s;
    rsp_done && last && ins_r.op == OP_LOAD;
  endsequence

  load_latency_a: assert property (load_last_s |=> done_o && instr_ready_o) // RQ14
    else $error("load finished late");
  zero_fill_a: assert property (rsp_done && ins_r.op == OP_LOAD && ins_r.size == SZ_BYTE // RQ13
                                |=> gpr_r[ins_r.dest_reg][31:8] == 24'h00_0000)
    else $error("byte load not zero filled");
  split_beat_a: assert property (rsp_done && !last |=> mem_req_valid_o && beat_r) // RQ11
    else $error("second beat missing");
  store_base_upd_a: assert property (rsp_done && last && ins_r.update && mem_req_o.write // RQ16
                                     |=> gpr_r[ins_r.base_reg] == ea_r)
    else $error("store update left base unchanged");
  one_outstanding_a: assert property (mem_req_valid_o && mem_req_ready_i // RQ7
                                      |=> !mem_req_valid_o)
    else $error("second request while one outstanding");

endmodule
`default_nettype wire

// ==== fpx_mem_model.sv ====
// cache-side model: word memory answering one beat at a time with stalls
`timescale 1ns/1ps
`default_nettype none
module fpx_mem_model
  import fpx_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         slow_i,
  input  wire logic         req_valid_i,
  input  wire fpx_mem_req_t req_i,
  output logic              req_ready_o,
  output logic              rsp_valid_o,
  output logic [31:0]       rsp_data_o
);
  logic [31:0] mem [1024];
  logic [31:0] rd_r;
  logic [3:0]  cnt_r;
  logic [1:0]  wait_r;
  logic        pend_r;
  logic [9:0]  widx;

  // ten word-address bits decode, so addresses wrap at 4 KB
  assign widx = req_i.word_addr[9:0];

  // accept after a stall, answer later; data toggles outside a response
  always @(posedge clk_i) begin
    cnt_r       <= cnt_r + 4'h1;
    req_ready_o <= 1'b0;
    rsp_valid_o <= 1'b0;
    rsp_data_o  <= ~rsp_data_o;
    if (rst_i) begin
      cnt_r      <= 4'h0;
      pend_r     <= 1'b0;
      rsp_data_o <= 32'h5A5A_A5A5;
    end else if (pend_r) begin
      wait_r <= wait_r - 2'h1;
      if (wait_r == 2'h0) begin
        pend_r      <= 1'b0;
        rsp_valid_o <= 1'b1;
        rsp_data_o  <= rd_r;
      end
    end else if (req_valid_i && req_ready_o) begin
      pend_r <= 1'b1;
      rd_r   <= mem[widx];
      wait_r <= slow_i ? cnt_r[1:0] : 2'h0;
      for (int b = 0; b < 4; b++) begin
        if (req_i.write && req_i.byte_en[3-b]) begin
          mem[widx][31-8*b -: 8] <= req_i.wdata[31-8*b -: 8];
        end
      end
    end else if (req_valid_i) begin
      req_ready_o <= !slow_i || cnt_r[0];
    end
  end
endmodule
`default_nettype wire

// ==== fp_status_move_int_load_store_exec_tb.sv ====
// self-checking bench for the fp status, fp move and load/store unit
`timescale 1ns/1ps
`default_nettype none
module fp_status_move_int_load_store_exec_tb
  import fpx_pkg::*;
;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            instr_valid_i = 1'b0;
  logic            fp_busy_i = 1'b0;
  logic            slow = 1'b0;
  logic            hold_q = 1'b0;
  logic            outst = 1'b0;
  logic [4:0]      dbg_gpr_sel_i = 5'h00;
  logic [4:0]      dbg_fpr_sel_i = 5'h00;
  logic [4:0]      k;
  fpx_instr_t      instr_i = '0;
  fpx_instr_t      n;
  fpx_mem_req_t    mem_req_o, req_q;
  fpx_fetch_attr_t fetch_attr_o;
  logic            instr_ready_o, fp_hold_o, mem_req_valid_o, mem_req_ready_i;
  logic            mem_rsp_valid_i, done_o, invalid_form_o;
  logic [31:0]     mem_rsp_data_i, dbg_gpr_o, fp_status_o, cond_reg_o;
  logic [31:0]     fs = FS_RESET;
  logic [31:0]     cr = CR_RESET;
  logic [31:0]     gpr [32];
  logic [31:0]     rmem [1024];
  logic [63:0]     dbg_fpr_o;
  logic [63:0]     fpr [32];
  int              fail_count = 0;
  int              comparisons = 0;
  int              takes = 0;
  int              seed = 32'h77DC16D0;
  int              lat, l2;

  always #25 clk_i = ~clk_i;

  fpx_exec fpx_exec_inst (.clk_i, .rst_i, .instr_valid_i, .instr_i, .instr_ready_o,
    .fp_busy_i, .fp_hold_o, .mem_req_valid_o, .mem_req_o, .mem_req_ready_i,
    .mem_rsp_valid_i, .mem_rsp_data_i, .fetch_attr_o, .done_o, .invalid_form_o,
    .dbg_gpr_sel_i, .dbg_gpr_o, .dbg_fpr_sel_i, .dbg_fpr_o, .fp_status_o, .cond_reg_o);

  fpx_mem_model fpx_mem_model_inst (.clk_i, .rst_i, .slow_i(slow),
    .req_valid_i(mem_req_valid_o), .req_i(mem_req_o), .req_ready_o(mem_req_ready_i),
    .rsp_valid_o(mem_rsp_valid_i), .rsp_data_o(mem_rsp_data_i));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // random instruction, stores may take an invalid form; fp source named in both source fields
  function automatic fpx_instr_t rnd(input fpx_op_t op);
    logic [95:0] r;
    logic [7:0]  m;
    fpx_instr_t  x;
    r = {$random(seed), $random(seed), $random(seed)};
    x = r[$bits(fpx_instr_t)-1:0];
    x.op = op;
    x.amode = fpx_amode_t'(x.amode % 2'h3);
    x.size = fpx_size_t'(x.size % 2'h3);
    x.algebraic = x.algebraic && x.size == SZ_HALF;
    x.record_bit = x.record_bit && op != OP_LOAD && (op != OP_STORE || x.bit_num[0]);
    x.index_reg = x.src_reg;
    m = x.field_select_mask;
    x.field_select_mask[3:0] = {m[4], m[5], m[6], m[7]};  // mirror-symmetric mask
    if (op == OP_LOAD && x.update && x.base_reg == REG_ZERO) x.base_reg = 5'h01;
    if (op == OP_FS_IMM) x.field_s = x.field_d;
    return x;
  endfunction

  // reference model: updates expected registers and memory
  task automatic model(input fpx_instr_t i, output bit inv);
    logic [31:0] ea, v, s, a;
    logic [63:0] f;
    int          nb;
    nb = (i.size == SZ_BYTE) ? 1 : (i.size == SZ_HALF) ? 2 : 4;
    ea = (i.base_reg == REG_ZERO && !i.update) ? 32'h0 : gpr[i.base_reg];
    if (i.amode == AM_DISP) ea += {{16{i.disp[15]}}, i.disp};
    if (i.amode == AM_INDEX) ea += gpr[i.index_reg];
    inv = i.op == OP_STORE && (i.record_bit || (i.update && i.base_reg == REG_ZERO));
    s = gpr[i.src_reg];
    f = fpr[i.src_reg];
    v = 32'h0;
    case (i.op)
      OP_LOAD: begin
        for (int b = 0; b < nb; b++) begin
          a = ea + b;
          v = {v[23:0], rmem[a[11:2]][31-8*a[1:0] -: 8]};
        end
        if (i.algebraic && nb == 2) v = {{16{v[15]}}, v[15:0]};
        if (i.update) gpr[i.base_reg] = ea;
        gpr[i.dest_reg] = v;
      end
      OP_STORE: if (!inv) begin
        for (int b = 0; b < nb; b++) begin
          a = ea + b;
          rmem[a[11:2]][31-8*a[1:0] -: 8] = s[8*(nb-1-b) +: 8];
        end
        if (i.update) gpr[i.base_reg] = ea;
      end
      OP_FMOVE: begin
        f[63] = (i.mv == MV_COPY) ? f[63] : (i.mv == MV_NEG) ? !f[63] : i.mv == MV_NABS;
        if (fs[FS_NI_IDX] && f[62:52] == FP_EXP_ZERO && f[51:0] != 52'h0) f = {f[63], 63'h0};
        fpr[i.dest_reg] = f;
      end
      OP_FS_READ: fpr[i.dest_reg] = {32'h0, fs};
      OP_FS_TO_CR: cr[31-4*i.field_d -: 4] = fs[31-4*i.field_s -: 4];
      OP_FS_CLR: fs[31-i.bit_num] = 1'b0;
      OP_FS_SET: fs[31-i.bit_num] = 1'b1;
      OP_FS_IMM: fs[31-4*i.field_d -: 4] = i.immediate_value;
      OP_FS_MASK: for (int b = 0; b < 8; b++) begin
        if (i.field_select_mask[b]) fs[4*b +: 4] = f[4*b +: 4];
      end
      default: ;
    endcase
    if (i.record_bit && i.op inside {[OP_FMOVE:OP_FS_MASK]} && i.op != OP_FS_TO_CR) begin
      cr[27:24] = fs[31:28];
    end
  endtask

  // compare register files, status, condition register and memory
  task automatic check_state();
    for (int i = 0; i < 32; i++) begin
      dbg_gpr_sel_i = 5'(i);
      dbg_fpr_sel_i = 5'(i);
      @(negedge clk_i);
      chk(dbg_gpr_o, gpr[i]);
      chk(dbg_fpr_o, fpr[i]);
    end
    chk(fp_status_o, fs);
    chk(cond_reg_o, cr);
    for (int i = 0; i < 1024; i++) chk(fpx_mem_model_inst.mem[i], rmem[i]);
  endtask

  // offer one instruction, hold fp busy for bz cycles, wait for its end
  task automatic run(input fpx_instr_t i, input int bz, output int c);
    bit inv;
    int t0, w;
    model(i, inv);
    t0 = takes;
    w = 0;
    @(negedge clk_i);
    instr_i = i;
    instr_valid_i = 1'b1;
    fp_busy_i = bz > 0;
    while (instr_ready_o !== 1'b1 && w < 500) begin
      @(negedge clk_i);
      w++;
    end
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    c = 0;
    while (done_o !== 1'b1 && invalid_form_o !== 1'b1 && c < 500) begin
      if (c >= bz) fp_busy_i = 1'b0;
      if (fp_busy_i) chk(fp_hold_o, 1);
      @(negedge clk_i);
      c++;
    end
    chk(fp_busy_i, 0);
    chk(invalid_form_o, inv);
    chk(done_o, !inv);
    if (inv) chk(takes - t0, 0);
    check_state();
  endtask

  // cache port watch: one beat outstanding, request held until accepted
  always @(posedge clk_i) begin
    if (mem_rsp_valid_i) outst = 1'b0;
    if (!rst_i && hold_q) chk(mem_req_valid_o && mem_req_o === req_q, 1);
    if (!rst_i && mem_req_valid_o && mem_req_ready_i) begin
      takes++;
      chk(outst, 0);
      outst = 1'b1;
    end
    hold_q = !rst_i && mem_req_valid_o && !mem_req_ready_i;
    req_q = mem_req_o;
    if (!rst_i) chk(fetch_attr_o, 0);
  end

  // the run needs some 10k cycles; cut it off at about eight times that
  initial begin
    #4_000_000;
    fail_count++;
    close_out();
  end

  initial begin
    for (int i = 0; i < 32; i++) begin
      gpr[i] = 32'h0;
      fpr[i] = 64'h0;
    end
    for (int i = 0; i < 1024; i++) begin
      rmem[i] = $random(seed);
      fpx_mem_model_inst.mem[i] = rmem[i];
    end
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    chk(instr_ready_o, 1);
    chk(mem_req_valid_o, 0);
    chk(fp_status_o, FS_RESET);
    chk(cond_reg_o, CR_RESET);
    // word load, algebraic half load, update half load: same latency
    n = rnd(OP_LOAD);
    n.amode = AM_DISP;
    n.update = 1'b0;
    n.size = SZ_WORD;
    n.base_reg = 5'h00;
    n.dest_reg = 5'h02;
    n.disp = 16'h0040;
    run(n, 0, lat);
    n.size = SZ_HALF;
    n.algebraic = 1'b1;
    n.disp = 16'h0042;
    run(n, 0, l2);
    chk(l2, lat);
    n.base_reg = 5'h01;
    n.update = 1'b1;
    n.disp = 16'h0044;
    run(n, 0, l2);
    chk(l2, lat);
    // status op waits for earlier fp work; masked update as fast as full
    run(rnd(OP_FS_SET), 6, lat);
    n = rnd(OP_FS_MASK);
    n.field_select_mask = 8'hFF;
    run(n, 0, lat);
    n.field_select_mask = 8'h81;
    run(n, 0, l2);
    chk(l2, lat);
    // store update with source as base, then the two invalid forms
    slow = 1'b1;
    n = rnd(OP_STORE);
    n.update = 1'b1;
    n.record_bit = 1'b0;
    n.base_reg = 5'h02;
    n.src_reg = 5'h02;
    run(n, 0, lat);
    n.record_bit = 1'b1;
    run(n, 0, lat);
    n.record_bit = 1'b0;
    n.base_reg = REG_ZERO;
    run(n, 0, lat);
    // random mix of every operation and address form
    for (int i = 0; i < 250; i++) begin
      n = rnd(fpx_op_t'(4'($unsigned($random(seed)) % 11)));
      run(n, n.op inside {[OP_FS_READ:OP_FS_MASK]} ? i % 4 : 0, lat);
    end
    // all move kinds on a denormal, non-ieee mode off then on
    for (int p = 0; p < 2; p++) begin
      n = rnd(p ? OP_FS_SET : OP_FS_CLR);
      n.bit_num = 5'h1F - FS_NI_IDX;
      run(n, 0, lat);
      n = rnd(OP_FS_READ);
      k = n.dest_reg;
      run(n, 0, lat);
      for (int m = 0; m < 8; m++) begin
        n = rnd(OP_FMOVE);
        n.src_reg = k;
        n.index_reg = k;
        n.mv = fpx_mv_t'(m[1:0]);
        n.record_bit = m[2];
        run(n, 0, lat);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
